// ==== src/meter_pkg.sv ====
// shared constants for the meter command and mode control link
package meter_pkg;
   // ****************************************
   // command byte layout
   // ****************************************
   localparam int cmd_width = 8;
   localparam int addr_width = 5;
   localparam int cmd_dir_bit = 7;
   localparam logic [1:0] cmd_pad_zero = 2'h0;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [4:0] operating_configuration_addr = 5'h06;
   localparam int cfg_width = 16;
   localparam logic [15:0] cfg_reset = 16'h000c;
   // widest register on the map, frames are sized in bits per address
   localparam int max_width = 40;
   localparam int len_width = 6;
   // ****************************************
   // configuration field positions
   // ****************************************
   localparam int highpass_bypass_bit = 0;
   localparam int power_lowpass_bypass_bit = 1;
   localparam int pulse_output_off_bit = 2;
   localparam int dip_detect_off_bit = 3;
   localparam int converters_powerdown_bit = 4;
   localparam int thermal_convert_start_bit = 5;
   localparam int soft_chip_reset_bit = 6;
   localparam int halfcycle_accumulate_mode_bit = 7;
   localparam int first_input_short_bit = 8;
   localparam int second_input_short_bit = 9;
   localparam int input_swap_bit = 10;
   localparam int waveform_rate_lo = 11;
   localparam int waveform_rate_hi = 12;
   localparam int waveform_source_lo = 13;
   localparam int waveform_source_hi = 14;
   localparam int factory_test_enable_bit = 15;
   // ****************************************
   // waveform source codes and lengths
   // ****************************************
   localparam logic [1:0] wave_src_power = 2'h0;
   localparam logic [1:0] wave_src_both = 2'h1;
   localparam logic [1:0] wave_src_first = 2'h2;
   localparam logic [1:0] wave_src_second = 2'h3;
   localparam logic [5:0] wave_len_both = 6'h28;
   localparam logic [5:0] wave_len_single = 6'h18;
   // rate divider base, shifted left by the rate code
   localparam logic [10:0] wave_div_base = 11'h080;
   // ****************************************
   // timing
   // ****************************************
   localparam int clk_mhz = 40;
   localparam int soft_reset_recovery_ns = 18000;
   localparam int soft_reset_recovery_cycles = (soft_reset_recovery_ns * clk_mhz + 999) / 1000;
   localparam int recovery_cnt_width = 10;
   // ****************************************
   // link states
   // ****************************************
   typedef enum logic [1:0] {idle_st, cmd_st, data_st} link_state_t;
   // bit width of the register at an address
   function automatic logic [5:0] reg_len(input logic [4:0] a);
      reg_len = (a == operating_configuration_addr) ? 6'h10 : 6'h08;
   endfunction : reg_len
endpackage : meter_pkg

// ==== src/meter_link_if.sv ====
// serial link between host controller and meter register port
`timescale 1ns/100ps
interface meter_link_if;
   logic frame_n;
   logic sclk;
   logic mosi;
   logic miso;
   logic miso_oe;
   modport device (input frame_n, input sclk, input mosi, output miso, output miso_oe);
   modport host (output frame_n, output sclk, output mosi, input miso, input miso_oe);
endinterface : meter_link_if

// ==== src/meter_device.sv ====
// device end: command byte, register read/write and mode register
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module meter_device (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // serial link
   meter_link_if.device link,
   // other registers, read side
   output logic [4:0] ext_addr,
   input wire logic [39:0] ext_rdata,
   // other registers, write side
   output logic ext_we,
   output logic [39:0] ext_wdata,
   // mode controls
   output logic highpass_bypass,
   output logic power_lowpass_bypass,
   output logic pulse_output_off,
   output logic dip_detect_off,
   output logic converters_powerdown,
   output logic thermal_convert_start,
   output logic soft_chip_reset,
   output logic halfcycle_accumulate_mode,
   output logic first_input_short,
   output logic second_input_short,
   output logic input_swap,
   output logic factory_test_enable,
   output logic [1:0] waveform_rate_select,
   output logic [1:0] waveform_source_select,
   output logic [5:0] waveform_length,
   output logic waveform_sample_tick,
   // conversion handshake
   input wire logic thermal_convert_done
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [1:0] frame_s_q, sclk_s_q, mosi_s_q;
   logic sclk_prev_q;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         frame_s_q <= 2'h3;
         sclk_s_q <= 2'h0;
         mosi_s_q <= 2'h0;
         sclk_prev_q <= 1'h0;
      end else begin
         frame_s_q <= {frame_s_q[0], link.frame_n};
         sclk_s_q <= {sclk_s_q[0], link.sclk};
         mosi_s_q <= {mosi_s_q[0], link.mosi};
         sclk_prev_q <= sclk_s_q[1];
      end
   end
   wire in_frame = !frame_s_q[1];
   wire rise = sclk_s_q[1] && !sclk_prev_q;
   wire fall = !sclk_s_q[1] && sclk_prev_q;
   // ****************************************
   // transfer state
   // ****************************************
   meter_pkg::link_state_t state_q;
   logic [7:0] cmd_q;
   logic [5:0] cnt_q;
   logic [39:0] sh_q;
   logic [15:0] cfg_q;
   logic [15:0] cfg_d;
   logic cfg_we;
   logic [39:0] rd_word;
   logic [5:0] len;
   assign len = meter_pkg::reg_len(cmd_q[4:0]);
   always_comb begin
      rd_word = ext_rdata;
      if (cmd_q[4:0] == meter_pkg::operating_configuration_addr) begin
         rd_word = {24'h000000, cfg_q};
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst || soft_chip_reset) begin
         state_q <= meter_pkg::idle_st;
         cmd_q <= 8'h00;
         cnt_q <= 6'h00;
         sh_q <= 40'h0;
      end else if (!in_frame) begin
         state_q <= meter_pkg::idle_st;
         cnt_q <= 6'h00;
      end else begin
         unique case (state_q)
            meter_pkg::idle_st: begin
               state_q <= meter_pkg::cmd_st;
               cnt_q <= 6'h00;
            end
            meter_pkg::cmd_st: if (rise) begin
               cmd_q <= {cmd_q[6:0], mosi_s_q[1]};
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == 6'(meter_pkg::cmd_width - 1)) begin
                  state_q <= meter_pkg::data_st;
                  cnt_q <= 6'h00;
               end
            end
            meter_pkg::data_st: begin
               // reads preload the word, writes start from zero so upper bits stay clear
               if (cnt_q == 6'h00 && !rise) begin
                  sh_q <= cmd_q[meter_pkg::cmd_dir_bit] ? 40'h0
                     : rd_word << (6'(meter_pkg::max_width) - len);
               end
               if (rise) begin
                  if (cmd_q[meter_pkg::cmd_dir_bit]) begin
                     sh_q <= {sh_q[38:0], mosi_s_q[1]};
                  end
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q == len - 6'h01) begin
                     state_q <= meter_pkg::cmd_st;
                     cnt_q <= 6'h00;
                  end
               end else if (fall && !cmd_q[meter_pkg::cmd_dir_bit] && cnt_q != 6'h00) begin
                  sh_q <= {sh_q[38:0], 1'h0};
               end
            end
            default: state_q <= meter_pkg::idle_st;
         endcase
      end
   end
   // write completes on last data bit
   logic wr_done;
   assign wr_done = in_frame && rise && state_q == meter_pkg::data_st && cmd_q[meter_pkg::cmd_dir_bit]
      && cnt_q == len - 6'h01;
   wire [39:0] wr_word = {sh_q[38:0], mosi_s_q[1]};
   // read data driven msb first; command byte never returned
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         link.miso <= 1'h0;
         link.miso_oe <= 1'h0;
      end else begin
         link.miso_oe <= in_frame && state_q == meter_pkg::data_st && !cmd_q[meter_pkg::cmd_dir_bit];
         link.miso <= sh_q[meter_pkg::max_width - 1];
      end
   end
   // ****************************************
   // external register port
   // ****************************************
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ext_addr <= 5'h00;
         ext_we <= 1'h0;
         ext_wdata <= 40'h0;
      end else begin
         ext_addr <= cmd_q[4:0];
         ext_we <= wr_done && cmd_q[4:0] != meter_pkg::operating_configuration_addr;
         if (wr_done) begin
            ext_wdata <= wr_word;
         end
      end
   end
   // ****************************************
   // mode register
   // ****************************************
   assign cfg_we = wr_done && cmd_q[4:0] == meter_pkg::operating_configuration_addr;
   always_comb begin
      cfg_d = cfg_q;
      if (thermal_convert_done) begin
         cfg_d[meter_pkg::thermal_convert_start_bit] = 1'h0;
      end
      if (cfg_we) begin
         cfg_d = wr_word[15:0];
      end
      if (soft_chip_reset) begin
         cfg_d = meter_pkg::cfg_reset;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cfg_q <= meter_pkg::cfg_reset;
      end else begin
         cfg_q <= cfg_d;
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         highpass_bypass <= 1'h0;
         power_lowpass_bypass <= 1'h0;
         pulse_output_off <= 1'h1;
         dip_detect_off <= 1'h1;
         converters_powerdown <= 1'h0;
         thermal_convert_start <= 1'h0;
         soft_chip_reset <= 1'h0;
         halfcycle_accumulate_mode <= 1'h0;
         first_input_short <= 1'h0;
         second_input_short <= 1'h0;
         input_swap <= 1'h0;
         factory_test_enable <= 1'h0;
         waveform_rate_select <= 2'h0;
         waveform_source_select <= 2'h0;
         waveform_length <= meter_pkg::wave_len_single;
      end else begin
         highpass_bypass <= cfg_d[meter_pkg::highpass_bypass_bit];
         power_lowpass_bypass <= cfg_d[meter_pkg::power_lowpass_bypass_bit];
         pulse_output_off <= cfg_d[meter_pkg::pulse_output_off_bit];
         dip_detect_off <= cfg_d[meter_pkg::dip_detect_off_bit];
         converters_powerdown <= cfg_d[meter_pkg::converters_powerdown_bit];
         thermal_convert_start <= cfg_d[meter_pkg::thermal_convert_start_bit];
         // one-cycle pulse, bit itself is not kept
         soft_chip_reset <= cfg_we && wr_word[meter_pkg::soft_chip_reset_bit] && !soft_chip_reset;
         halfcycle_accumulate_mode <= cfg_d[meter_pkg::halfcycle_accumulate_mode_bit];
         first_input_short <= cfg_d[meter_pkg::first_input_short_bit];
         second_input_short <= cfg_d[meter_pkg::second_input_short_bit];
         input_swap <= cfg_d[meter_pkg::input_swap_bit];
         factory_test_enable <= cfg_d[meter_pkg::factory_test_enable_bit];
         waveform_rate_select <= cfg_d[meter_pkg::waveform_rate_hi:meter_pkg::waveform_rate_lo];
         waveform_source_select <= cfg_d[meter_pkg::waveform_source_hi:meter_pkg::waveform_source_lo];
         waveform_length <= (cfg_d[meter_pkg::waveform_source_hi:meter_pkg::waveform_source_lo]
            == meter_pkg::wave_src_both) ? meter_pkg::wave_len_both : meter_pkg::wave_len_single;
      end
   end
   // ****************************************
   // waveform rate divider
   // ****************************************
   logic [10:0] div_q;
   wire [10:0] div_top = meter_pkg::wave_div_base << waveform_rate_select;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         div_q <= 11'h000;
         waveform_sample_tick <= 1'h0;
      end else begin
         waveform_sample_tick <= div_q >= div_top - 11'h001;
         div_q <= (div_q >= div_top - 11'h001) ? 11'h000 : div_q + 11'h001;
      end
   end
endmodule : meter_device

// ==== src/meter_host.sv ====
// host end: sends command byte then register data on the serial link
`timescale 1ns/100ps
module meter_host (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // serial link
   meter_link_if.host link,
   // software port
   input wire logic [4:0] addr,
   input wire logic [39:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [39:0] rdata,
   output logic busy,
   output logic done
);
   // ****************************************
   // serial engine
   // ****************************************
   localparam logic [9:0] rec_cnt = 10'(meter_pkg::soft_reset_recovery_cycles);
   logic [1:0] miso_s_q;
   logic [7:0] cmd_q;
   logic [39:0] sh_q;
   logic [39:0] rx_q;
   logic [5:0] cnt_q;
   logic [5:0] len_q;
   logic [2:0] ph_q;
   logic [9:0] rec_q;
   logic is_wr_q;
   logic srst_q;
   meter_pkg::link_state_t state_q;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         miso_s_q <= 2'h0;
      end else begin
         miso_s_q <= {miso_s_q[0], link.miso};
      end
   end
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_q <= meter_pkg::idle_st;
         link.frame_n <= 1'h1;
         link.sclk <= 1'h0;
         link.mosi <= 1'h0;
         cmd_q <= 8'h00;
         sh_q <= 40'h0;
         rx_q <= 40'h0;
         cnt_q <= 6'h00;
         len_q <= 6'h00;
         ph_q <= 3'h0;
         rec_q <= 10'h000;
         is_wr_q <= 1'h0;
         srst_q <= 1'h0;
         busy <= 1'h0;
         done <= 1'h0;
         rdata <= 40'h0;
      end else begin
         done <= 1'h0;
         if (rec_q != 10'h000) begin
            rec_q <= rec_q - 10'h001;
         end
         unique case (state_q)
            meter_pkg::idle_st: if ((wr || rd) && rec_q == 10'h000) begin
               // command first, pad bits zero
               cmd_q <= {wr, meter_pkg::cmd_pad_zero, addr};
               len_q <= meter_pkg::reg_len(addr);
               // factory test bit forced to zero
               sh_q <= (addr == meter_pkg::operating_configuration_addr) ?
                  {1'h0, wdata[14:0], 24'h0} : wdata << (6'(meter_pkg::max_width) - meter_pkg::reg_len(addr));
               is_wr_q <= wr;
               // recovery is counted from the end of the soft reset frame
               srst_q <= wr && addr == meter_pkg::operating_configuration_addr &&
                  wdata[meter_pkg::soft_chip_reset_bit];
               rx_q <= 40'h0;
               busy <= 1'h1;
               link.frame_n <= 1'h0;
               cnt_q <= 6'h00;
               ph_q <= 3'h0;
               state_q <= meter_pkg::cmd_st;
            end
            default: begin
               // eight-phase bit: set data, wait, rise, wait, fall, advance
               ph_q <= ph_q + 3'h1;
               if (ph_q == 3'h0) begin
                  link.mosi <= (state_q == meter_pkg::cmd_st) ? cmd_q[7] : sh_q[39];
               end else if (ph_q == 3'h3) begin
                  link.sclk <= 1'h1;
               end else if (ph_q == 3'h6) begin
                  link.sclk <= 1'h0;
                  // only data bits are collected, result stays right-aligned
                  if (state_q == meter_pkg::data_st) begin
                     rx_q <= {rx_q[38:0], miso_s_q[1]};
                  end
               end else if (ph_q == 3'h7) begin
                  cnt_q <= cnt_q + 6'h01;
                  if (state_q == meter_pkg::cmd_st) begin
                     cmd_q <= {cmd_q[6:0], 1'h0};
                     if (cnt_q == 6'(meter_pkg::cmd_width - 1)) begin
                        state_q <= meter_pkg::data_st;
                        cnt_q <= 6'h00;
                     end
                  end else begin
                     sh_q <= {sh_q[38:0], 1'h0};
                     if (cnt_q == len_q - 6'h01) begin
                        state_q <= meter_pkg::idle_st;
                        link.frame_n <= 1'h1;
                        busy <= 1'h0;
                        done <= 1'h1;
                        if (!is_wr_q) begin
                           rdata <= rx_q;
                        end
                        if (srst_q) begin
                           rec_q <= rec_cnt;
                        end
                     end
                  end
               end
            end
         endcase
      end
   end
endmodule : meter_host

// ==== bench/meter_link_monitor.sv ====
// concurrent checks on the serial link between host and device
`timescale 1ns/100ps
module meter_link_monitor (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // serial link
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   // ****************************************
   // frame tracking
   // ****************************************
   logic sclk_q;
   logic [5:0] cnt_q;
   logic [7:0] cmd_q;
   logic rise;
   assign rise = sclk & !sclk_q;
   always_ff @(posedge mclk) begin
      sclk_q <= nrst ? sclk : 1'b0;
   end
   // sclk rises seen in the running frame
   always_ff @(posedge mclk) begin
      if (!nrst || frame_n) begin
         cnt_q <= 6'h00;
      end else if (rise) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
   // first eight bits of a frame form the command
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cmd_q <= 8'h00;
      end else if (rise && !frame_n && cnt_q < 6'h08) begin
         cmd_q <= {cmd_q[6:0], mosi};
      end
   end
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_frame_len;
      $rose(frame_n) |-> cnt_q == ((cmd_q[4:0] == 5'h06) ? 6'h18 : 6'h10);
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
   property p_pad_zero;
      (cnt_q == 6'h08 && !frame_n) |-> cmd_q[6:5] == 2'h0;
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("command pad bits not zero");
   property p_oe_read;
      miso_oe |-> !cmd_q[7];
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("device drives data on a write");
   property p_oe_after_cmd;
      $rose(miso_oe) |-> cnt_q == 6'h08;
   endproperty
   a_oe_after_cmd: assert property (p_oe_after_cmd) else $error("read data not right after command");
   property p_idle_sclk;
      frame_n |-> !sclk;
   endproperty
   a_idle_sclk: assert property (p_idle_sclk) else $error("clock moves outside frame");
   property p_sclk_high;
      $rose(sclk) |=> sclk [*2] ##1 !sclk;
   endproperty
   a_sclk_high: assert property (p_sclk_high) else $error("clock high time wrong");
   property p_sclk_low;
      ($fell(sclk) && !frame_n) |-> (!sclk) [*5];
   endproperty
   a_sclk_low: assert property (p_sclk_low) else $error("clock low time too short");
   property p_mosi_stable;
      sclk |-> $stable(mosi);
   endproperty
   a_mosi_stable: assert property (p_mosi_stable) else $error("host data moves while clock high");
   property p_frame_gap;
      $rose(frame_n) |=> frame_n;
   endproperty
   a_frame_gap: assert property (p_frame_gap) else $error("frames back to back");
endmodule : meter_link_monitor

// ==== bench/meter_command_and_mode_control_bench.sv ====
// self-checking bench for the host and device ends of the meter link
`timescale 1ns/100ps
module meter_command_and_mode_control_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [39:0] wdata = 40'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [39:0] rdata;
   logic busy;
   logic done;
   logic [4:0] ext_addr;
   logic [39:0] ext_rdata = 40'h0;
   logic ext_we;
   logic [39:0] ext_wdata;
   logic hpf, lpf, pof, ddo, cpd, tcs, scr, ham, fis, sis, isw, fte, tick;
   logic [1:0] wrs, wss;
   logic [5:0] wlen;
   logic thermal_convert_done = 1'b0;
   int error_cnt = 0;
   int cmp_count = 0;
   int sr_seen = 0;
   logic [40:0] rd_q[$];
   logic [44:0] we_q[$];
   always #12.5 mclk = ~mclk;
   meter_link_if link ();
   meter_host meter_host_inst (.mclk(mclk), .nrst(nrst), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .busy(busy), .done(done));
   meter_device meter_device_inst (.mclk(mclk), .nrst(nrst), .link(link), .ext_addr(ext_addr),
      .ext_rdata(ext_rdata), .ext_we(ext_we), .ext_wdata(ext_wdata), .highpass_bypass(hpf),
      .power_lowpass_bypass(lpf), .pulse_output_off(pof), .dip_detect_off(ddo), .converters_powerdown(cpd),
      .thermal_convert_start(tcs), .soft_chip_reset(scr), .halfcycle_accumulate_mode(ham),
      .first_input_short(fis), .second_input_short(sis), .input_swap(isw), .factory_test_enable(fte),
      .waveform_rate_select(wrs), .waveform_source_select(wss), .waveform_length(wlen),
      .waveform_sample_tick(tick), .thermal_convert_done(thermal_convert_done));
   meter_link_monitor meter_link_monitor_inst (.mclk(mclk), .nrst(nrst), .frame_n(link.frame_n),
      .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
   function automatic logic [15:0] mode_out();
      mode_out = {fte, wss, wrs, isw, sis, fis, ham, 1'b0, tcs, cpd, ddo, pof, lpf, hpf};
   endfunction : mode_out
   task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   // r high reads, e is the expected read result
   task automatic xfer(input logic r, input logic [4:0] a, input logic [39:0] d, input logic [39:0] e);
      int n;
      rd_q.push_back({r, e});
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      rd <= r;
      wr <= !r;
      @(posedge mclk);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk);
      chk("busy", {39'h0, busy}, 40'h1);
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000) chk("done", 40'h0, 40'h1);
   endtask : xfer
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      while (tick !== 1'b1 && n < 2100) begin
         @(posedge mclk);
         n++;
      end
      @(posedge mclk);
      n = 1;
      while (tick !== 1'b1 && n < 2100) begin
         @(posedge mclk);
         n++;
      end
      chk("tick_gap", 40'(n), 40'(exp));
   endtask : tick_gap
   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge mclk) begin
      logic [40:0] note;
      logic [44:0] wn;
      if (done === 1'b1 && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         if (note[40]) chk("rdata", rdata, note[39:0]);
         chk("busy", {39'h0, busy}, 40'h0);
      end
      if (ext_we === 1'b1 && we_q.size() > 0) begin
         wn = we_q.pop_front();
         chk("ext_addr", {35'h0, ext_addr}, {35'h0, wn[44:40]});
         chk("ext_wdata", ext_wdata, wn[39:0]);
      end
      if (scr === 1'b1) sr_seen++;
   end
   initial begin
      #1500000;
      chk("timeout", 40'h0, 40'h1);
      report_and_stop();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int v;
      logic [15:0] e;
      logic [7:0] d;
      logic [4:0] a;
      void'($urandom(32'h2f413a1e));
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      chk("mode", {24'h0, mode_out()}, 40'h000c);
      chk("wlen", {34'h0, wlen}, 40'h18);
      xfer(1'b1, 5'h06, 40'h0, 40'h000c);
      for (int b = 0; b < 16; b++) begin
         v = 1 << b;
         e = (b == 6) ? 16'h000c : 16'(v) & 16'h7fbf;
         xfer(1'b0, 5'h06, 40'(v), 40'h0);
         repeat (4) @(posedge mclk);
         chk("mode", {24'h0, mode_out()}, {24'h0, e});
         if (b == 6) repeat (740) @(posedge mclk);
         xfer(1'b1, 5'h06, 40'h0, {24'h0, e});
      end
      chk("soft_reset", 40'(sr_seen), 40'h1);
      for (int i = 0; i < 4; i++) begin
         v = (i << 13) | (i << 11);
         xfer(1'b0, 5'h06, 40'(v), 40'h0);
         repeat (4) @(posedge mclk);
         chk("wlen", {34'h0, wlen}, (i == 1) ? 40'h28 : 40'h18);
         tick_gap(128 << i);
      end
      xfer(1'b0, 5'h06, 40'h0020, 40'h0);
      repeat (4) @(posedge mclk);
      chk("thermal", {39'h0, tcs}, 40'h1);
      thermal_convert_done <= 1'b1;
      @(posedge mclk);
      thermal_convert_done <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("thermal", {39'h0, tcs}, 40'h0);
      xfer(1'b1, 5'h06, 40'h0, 40'h0);
      // random mode values and other registers, back to back
      for (int k = 0; k < 12; k++) begin
         e = 16'($urandom) & 16'h7f9f;
         xfer(1'b0, 5'h06, {24'h0, e}, 40'h0);
         xfer(1'b1, 5'h06, 40'h0, {24'h0, e});
         a = 5'($urandom);
         if (a == 5'h06) a = 5'h07;
         d = 8'($urandom);
         we_q.push_back({a, 32'h0, d});
         xfer(1'b0, a, {32'h0, d}, 40'h0);
         ext_rdata <= {32'($urandom), ~d};
         xfer(1'b1, a, 40'h0, {32'h0, ~d});
      end
      report_and_stop();
   end
endmodule : meter_command_and_mode_control_bench
